// File: hw/ifn_edge_det.sv
`timescale 1ns/100ps
module ifn_edge_det #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [W-1:0] pin,
  input wire logic [W-1:0] rise,
  output logic [W-1:0] edge_o
);
  logic [W-1:0] prev_q;

  if (W < 1) begin : g_bad
    $error("ifn_edge_det: W must be at least 1");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_q <= '0;
    else if (en) prev_q <= pin;
  end

  // A change towards the selected level; rise=1 picks rising edges
  assign edge_o = en ? ((pin ^ prev_q) & ~(pin ^ rise)) : '0;
endmodule // ifn_edge_det

// File: hw/ifn_irq_flags.sv
`timescale 1ns/100ps
`include "ifn_params.svh"
module ifn_irq_flags #(
  parameter int NPINS = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ifn_pkg::ifn_periph_s periph,
  input wire ifn_pkg::ifn_cpu_s cpu,
  input wire logic nmi_pin,
  input wire logic [NPINS-1:0] irq_pin,
  input wire logic nmi_ack,
  output logic int_req,
  output logic [4:0] int_level,
  output ifn_pkg::ifn_src_e int_src,
  output logic nmi_req,
  output logic wake
);
  if (NPINS < 1 || NPINS > 8) begin : g_bad
    $error("ifn_irq_flags: NPINS must be 1 to 8");
  end

  logic [7:0] flags_a_q;
  logic [7:0] flags_a_d;
  logic [7:0] flags_b_q;
  logic [7:0] flags_b_d;
  logic nmi_rise_q;
  logic mask_all_q;
  logic override_q;
  logic [NPINS-1:0] edge_mode_q;
  logic [15:0] prio_c_q;
  logic [15:0] prio_d_q;
  logic [NPINS-1:0] pin_flag_q;
  logic [NPINS-1:0] pin_flag_d;
  logic [NPINS-1:0] read_one_q;
  logic [NPINS-1:0] read_one_d;
  logic nmi_pend_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic int_req_q;
  logic [4:0] int_level_q;
  ifn_pkg::ifn_src_e int_src_q;
  logic nmi_req_q;
  logic wake_q;

  // APB decode: read data is prepared in the setup cycle, answer in the first access cycle
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_q;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_fa = paddr == `IFN_OFF_FLAGS_A;
  wire hit_fb = paddr == `IFN_OFF_FLAGS_B;
  wire hit_ca = paddr == `IFN_OFF_CTRL_A;
  wire hit_cb = paddr == `IFN_OFF_CTRL_B;
  wire hit_pc = paddr == `IFN_OFF_PRIO_C;
  wire hit_pd = paddr == `IFN_OFF_PRIO_D;
  wire hit_pf = paddr == `IFN_OFF_PIN_FLAGS;
  wire hit_st = paddr == `IFN_OFF_STATUS;
  wire hit = hit_fa | hit_fb | hit_ca | hit_cb | hit_pc | hit_pd | hit_pf | hit_st;
  wire wr_ca = wr & hit_ca;
  wire wr_cb = wr & hit_cb;
  wire wr_pc = wr & hit_pc;
  wire wr_pd = wr & hit_pd;
  wire wr_pf = wr & hit_pf;
  wire rd_pf = rd & hit_pf;

  // Peripheral flags are fixed wiring of the live request lines
  always_comb begin
    flags_a_d = `IFN_FLAGS_RST;
    flags_a_d[`IFN_A_TX] = periph.port_a_tx;
    flags_a_d[`IFN_A_RX] = periph.port_a_rx;
    flags_a_d[`IFN_A_ERR] = periph.port_a_err;
    flags_a_d[3:0] = periph.dma_end;
    flags_b_d = `IFN_FLAGS_RST;
    flags_b_d[`IFN_B_CONV] = periph.conv_end;
    flags_b_d[`IFN_B_TX] = periph.port_b_tx;
    flags_b_d[`IFN_B_RX] = periph.port_b_rx;
    flags_b_d[`IFN_B_ERR] = periph.port_b_err;
  end

  // Pins run at the RTC tick rate in standby, when the peripheral clock would be stopped
  wire pin_en = cpu.standby ? cpu.rtc_tick : 1'b1;
  wire [NPINS-1:0] pin_edge;
  wire nmi_edge;

  ifn_edge_det #(
    .W(NPINS)
  ) u_pin_edge (
    .pclk(pclk),
    .presetn(presetn),
    .en(pin_en),
    .pin(irq_pin),
    .rise({NPINS{1'b1}}),
    .edge_o(pin_edge)
  );

  ifn_edge_det #(
    .W(1)
  ) u_nmi_edge (
    .pclk(pclk),
    .presetn(presetn),
    .en(1'b1),
    .pin(nmi_pin),
    .rise(nmi_rise_q),
    .edge_o(nmi_edge)
  );

  // Only a bit seen as 1 by a read may be cleared, so a fresh edge is never lost
  wire [NPINS-1:0] clr = {NPINS{wr_pf}} & ~pwdata[NPINS-1:0] & read_one_q & edge_mode_q;
  // Named so the checks can look one cycle back at them
  wire [NPINS-1:0] clr_only = clr & ~pin_edge;
  wire [NPINS-1:0] edge_keep = pin_flag_q & edge_mode_q & ~clr;

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (edge_mode_q[i]) pin_flag_d[i] = pin_edge[i] | (pin_flag_q[i] & ~clr[i]);
      else pin_flag_d[i] = pin_en ? irq_pin[i] : pin_flag_q[i];
    end
  end

  assign read_one_d = rd_pf ? (read_one_q | prdata_q[NPINS-1:0]) : (read_one_q & ~clr);

  wire [31:0] prio_all = {prio_d_q, prio_c_q};
  wire [3:0] pin_best;

  ifn_prio #(
    .N(NPINS)
  ) u_prio (
    .lvl(prio_all[4*NPINS-1:0]),
    .req(pin_flag_q),
    .best(pin_best)
  );

  wire low_power = cpu.sleep | cpu.standby;
  wire nmi_ok = ~mask_all_q & (override_q | ~cpu.cpu_block_bit | low_power);
  wire nmi_take = nmi_pend_q & nmi_ok;
  wire pin_take = pin_best > cpu.cpu_mask_level;
  // Only a level is offered; the CPU mask level gates the pins here, never the NMI
  wire [4:0] level_d = nmi_take ? `IFN_NMI_LEVEL : (pin_take ? {1'b0, pin_best} : 5'h00);
  wire ifn_pkg::ifn_src_e src_d = nmi_take ? ifn_pkg::IFN_SRC_NMI :
                                  (pin_take ? ifn_pkg::IFN_SRC_PIN : ifn_pkg::IFN_SRC_NONE);
  wire wake_d = (nmi_take & low_power) | (cpu.standby & cpu.rtc_in_use & pin_take);

  wire [31:0] status_w = {23'h000000, nmi_pend_q, nmi_ok, src_d, level_d};
  wire [31:0] ca_w = {31'h00000000, nmi_rise_q};
  wire [31:0] cb_w = {16'h0000, mask_all_q, override_q, 6'h00, 8'(edge_mode_q)};

  // Byte-wide registers sit in the low bits of the word; the rest reads zero
  function automatic logic [31:0] word8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  wire [31:0] rd_mux = hit_fa ? word8(flags_a_q) :
                       hit_fb ? word8(flags_b_q) :
                       hit_ca ? ca_w :
                       hit_cb ? cb_w :
                       hit_pc ? {16'h0000, prio_c_q} :
                       hit_pd ? {16'h0000, prio_d_q} :
                       hit_pf ? word8(8'(pin_flag_q)) :
                       hit_st ? status_w : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      if (setup & ~pwrite) prdata_q <= rd_mux;
    end
  end

  // Read-only flags: writes to them are accepted and dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_a_q <= `IFN_FLAGS_RST;
      flags_b_q <= `IFN_FLAGS_RST;
    end else begin
      flags_a_q <= flags_a_d;
      flags_b_q <= flags_b_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_rise_q <= 1'b0;
      mask_all_q <= 1'b0;
      override_q <= 1'b0;
      edge_mode_q <= '0;
      prio_c_q <= `IFN_PRIO_RST;
      prio_d_q <= `IFN_PRIO_RST;
    end else begin
      if (wr_ca) nmi_rise_q <= pwdata[`IFN_CA_NMI_RISE];
      if (wr_cb) mask_all_q <= pwdata[`IFN_CB_MASK_ALL];
      if (wr_cb) override_q <= pwdata[`IFN_CB_OVERRIDE];
      if (wr_cb) edge_mode_q <= pwdata[NPINS-1:0];
      if (wr_pc) prio_c_q <= pwdata[15:0];
      if (wr_pd) prio_d_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_flag_q <= '0;
      read_one_q <= '0;
      nmi_pend_q <= 1'b0;
    end else begin
      pin_flag_q <= pin_flag_d;
      read_one_q <= read_one_d;
      nmi_pend_q <= nmi_edge | (nmi_pend_q & ~nmi_ack);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_req_q <= 1'b0;
      int_level_q <= 5'h00;
      int_src_q <= ifn_pkg::IFN_SRC_NONE;
      nmi_req_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      int_req_q <= nmi_take | pin_take;
      int_level_q <= level_d;
      int_src_q <= src_d;
      nmi_req_q <= nmi_take;
      wake_q <= wake_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign int_req = int_req_q;
  assign int_level = int_level_q;
  assign int_src = int_src_q;
  assign nmi_req = nmi_req_q;
  assign wake = wake_q;

  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);

  port_a_map_a: assert property (1 |=> flags_a_q[7] == $past(periph.port_a_tx) &&
    flags_a_q[5] == $past(periph.port_a_rx) && flags_a_q[4] == $past(periph.port_a_err))
    else $error("port A flag does not follow its request");
  dma_map_a: assert property (1 |=> flags_a_q[3:0] == $past(periph.dma_end))
    else $error("DMA end flags do not follow their requests");
  rsv_read_a: assert property (setup && !pwrite && hit_fb |=> prdata_q[7:5] == 3'h0 && prdata_q[2] == 1'b0)
    else $error("reserved bits of flags B read nonzero");
  conv_map_a: assert property ($rose(periph.conv_end) |=> flags_b_q[4])
    else $error("conversion end flag missed");
  port_b_map_a: assert property (1 |=> flags_b_q[3] == $past(periph.port_b_tx) &&
    flags_b_q[1] == $past(periph.port_b_rx) && flags_b_q[0] == $past(periph.port_b_err))
    else $error("port B flag does not follow its request");
  pin_level_a: assert property (int_src_q == ifn_pkg::IFN_SRC_PIN |->
    int_level_q != 5'h00 && int_level_q < 5'h10 && int_req_q)
    else $error("pin request at an illegal level");
  nmi_level_a: assert property (int_src_q == ifn_pkg::IFN_SRC_NMI |-> int_level_q == 5'h10 && nmi_req_q)
    else $error("NMI not at level 16");
  nmi_accept_a: assert property (nmi_pend_q && !mask_all_q && (override_q || !cpu.cpu_block_bit)
    |=> nmi_req_q)
    else $error("NMI refused while acceptable");
  nmi_edge_a: assert property ($rose(nmi_pin) && nmi_rise_q |=> nmi_pend_q)
    else $error("NMI edge not latched");
  nmi_sleep_a: assert property (nmi_pend_q && !mask_all_q && cpu.sleep |=> nmi_req_q ##0 wake_q)
    else $error("NMI not taken in sleep");
  nmi_refuse_a: assert property (mask_all_q |=> !nmi_req_q)
    else $error("NMI taken with mask-all set");
  pin_clear_a: assert property (clr_only != '0 |=> (pin_flag_q & $past(clr_only)) == '0)
    else $error("edge flag not cleared");
  level_follow_a: assert property (!cpu.standby && edge_mode_q == '0 ##1 edge_mode_q == '0
    |-> pin_flag_q == $past(irq_pin))
    else $error("level flag does not follow pin");
  level_drop_a: assert property (edge_mode_q == '0 && !cpu.standby && irq_pin == '0 |=> pin_flag_q == '0)
    else $error("level flag stays set after the pin drops");

  // Flag registers: reserved bits, read-only behaviour, withdrawal of a request
  rsv_bit6_a: assert property (setup && !pwrite && hit_fa |=> prdata_q[6] == 1'b0)
    else $error("reserved bit of flags A reads nonzero");
  flags_ro_a: assert property (wr && hit_fa |=> flags_a_q == $past(flags_a_d))
    else $error("write to flags A changed them");
  conv_drop_a: assert property ($fell(periph.conv_end) |=> !flags_b_q[4])
    else $error("conversion end flag kept after withdrawal");
  rd_upper_a: assert property (setup && !pwrite && hit_pf |=> prdata_q[31:8] == 24'h000000)
    else $error("pin flag word has upper bits set");

  // Ranking: level 0 never requests, NMI always outranks the pins
  lvl0_mask_a: assert property (int_req_q |-> int_level_q != 5'h00)
    else $error("request raised at level 0");
  src_none_a: assert property (!int_req_q |-> int_src_q == ifn_pkg::IFN_SRC_NONE && int_level_q == 5'h00)
    else $error("idle request shows a source or level");
  pin_mask_a: assert property (!nmi_take && pin_best <= cpu.cpu_mask_level |=> !int_req_q)
    else $error("pin request at or below the mask level");
  prio_pick_a: assert property (pin_take && !nmi_take |=> int_level_q == {1'b0, $past(pin_best)})
    else $error("pin request not at the best programmed level");
  nmi_wins_a: assert property (nmi_take |=> int_src_q == ifn_pkg::IFN_SRC_NMI && int_level_q == 5'h10)
    else $error("NMI did not outrank the pins");

  // NMI detection and acceptance; a pending NMI survives the mask-all bit
  nmi_fall_a: assert property ($fell(nmi_pin) && !nmi_rise_q |=> nmi_pend_q)
    else $error("falling NMI edge not latched");
  nmi_ack_a: assert property (nmi_ack && !nmi_edge |=> !nmi_pend_q)
    else $error("NMI still pending after acknowledge");
  blk_refuse_a: assert property (!override_q && cpu.cpu_block_bit && !cpu.sleep && !cpu.standby
    |=> !nmi_req_q)
    else $error("NMI taken while blocked");
  nmi_stby_a: assert property (nmi_pend_q && !mask_all_q && cpu.standby |=> nmi_req_q ##0 wake_q)
    else $error("NMI not taken in standby");
  nmi_hold_a: assert property (mask_all_q && nmi_pend_q && !nmi_ack |=> nmi_pend_q)
    else $error("masked NMI lost its pending state");
  wake_off_a: assert property (!cpu.sleep && !cpu.standby |=> !wake_q)
    else $error("wake raised outside sleep and standby");

  // Edge-mode pin flags: an edge sets, only a qualified clear drops
  edge_set_a: assert property (pin_edge != '0 |=> (pin_flag_q & $past(pin_edge)) == $past(pin_edge))
    else $error("pin edge not latched");
  edge_keep_a: assert property (edge_keep != '0 |=> (pin_flag_q & $past(edge_keep)) == $past(edge_keep))
    else $error("edge flag lost without a clear");

  // Standby: pins only advance on the RTC tick, and a pin wake needs the RTC
  stby_hold_a: assert property (cpu.standby && !cpu.rtc_tick && !wr_pf |=> pin_flag_q == $past(pin_flag_q))
    else $error("pin flags moved without an RTC tick");
  pin_wake_a: assert property (cpu.standby && cpu.rtc_in_use && pin_take |=> wake_q)
    else $error("pin request did not wake standby");
  no_rtc_a: assert property (!cpu.rtc_in_use && !nmi_take |=> !wake_q)
    else $error("pin wake without the RTC in use");

  // Bus handshake: one-cycle answer, error on unmapped offsets
  apb_ready_a: assert property (setup |=> pready_q ##1 !pready_q)
    else $error("ready not a single cycle after setup");
  unmapped_a: assert property (setup && !hit |=> pslverr_q)
    else $error("unmapped offset gave no error");

  nmi_taken_c: cover property (nmi_edge ##[1:4] nmi_req_q);
  pin_clear_c: cover property (rd_pf ##[1:8] (clr != '0));
  standby_wake_c: cover property (cpu.standby && cpu.rtc_in_use && pin_take ##1 wake_q);
  unmapped_c: cover property (pslverr_q);
  standby_nmi_c: cover property (cpu.standby && nmi_take ##1 wake_q);
endmodule // ifn_irq_flags

// File: hw/ifn_params.svh
`ifndef IFN_PARAMS_SVH
`define IFN_PARAMS_SVH
`define IFN_OFF_FLAGS_A 8'h00
`define IFN_OFF_FLAGS_B 8'h04
`define IFN_OFF_CTRL_A 8'h08
`define IFN_OFF_CTRL_B 8'h0C
`define IFN_OFF_PRIO_C 8'h10
`define IFN_OFF_PRIO_D 8'h14
`define IFN_OFF_PIN_FLAGS 8'h18
`define IFN_OFF_STATUS 8'h1C
`define IFN_A_TX 7
`define IFN_A_RX 5
`define IFN_A_ERR 4
`define IFN_B_CONV 4
`define IFN_B_TX 3
`define IFN_B_RX 1
`define IFN_B_ERR 0
`define IFN_CA_NMI_RISE 0
`define IFN_CB_MASK_ALL 15
`define IFN_CB_OVERRIDE 14
`define IFN_FLAGS_RST 8'h00
`define IFN_PRIO_RST 16'h0000
`define IFN_NMI_LEVEL 5'h10
`endif

// File: hw/ifn_pkg.sv
package ifn_pkg;
  typedef struct packed {
    logic port_a_tx;
    logic port_a_rx;
    logic port_a_err;
    logic [3:0] dma_end;
    logic conv_end;
    logic port_b_tx;
    logic port_b_rx;
    logic port_b_err;
  } ifn_periph_s;
  typedef struct packed {
    logic cpu_block_bit;
    logic [3:0] cpu_mask_level;
    logic sleep;
    logic standby;
    logic rtc_in_use;
    logic rtc_tick;
  } ifn_cpu_s;
  typedef enum logic [1:0] {IFN_SRC_NONE, IFN_SRC_NMI, IFN_SRC_PIN} ifn_src_e;
endpackage

// File: hw/ifn_prio.sv
`timescale 1ns/100ps
module ifn_prio #(
  parameter int N = 6
) (
  input wire logic [4*N-1:0] lvl,
  input wire logic [N-1:0] req,
  output logic [3:0] best
);
  if (N < 1) begin : g_bad
    $error("ifn_prio: N must be at least 1");
  end

  // Level 0 never beats the start value, so a zero-level source is ignored
  function automatic logic [3:0] pick(input logic [4*N-1:0] l, input logic [N-1:0] r);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (r[i] && (l[4*i+:4] > m)) m = l[4*i+:4];
    end
    return m;
  endfunction

  assign best = pick(lvl, req);
endmodule // ifn_prio

// File: verification/ifn_cpu_partner.sv
`timescale 1ns/100ps
module ifn_cpu_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic nmi_req,
  output logic nmi_ack
);
  logic [2:0] cnt_q;
  // Only acknowledges; the mask level stays as the bench set it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      nmi_ack <= 1'b0;
    end else begin
      nmi_ack <= nmi_req && !nmi_ack && (cnt_q >= (slow ? 3'h5 : 3'h0));
      cnt_q <= (nmi_req && !nmi_ack) ? cnt_q + 3'h1 : 3'h0;
    end
  end
endmodule // ifn_cpu_partner

// File: verification/tb_irq_flags_and_nmi_detect.sv
`timescale 1ns/100ps
module tb_irq_flags_and_nmi_detect;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_pin = 0, slow = 0, er;
  logic pready, pslverr, int_req, nmi_req, wake, nmi_ack;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [4:0] int_level;
  logic [5:0] irq_pin = 6'h00;
  logic [10:0] p;
  ifn_pkg::ifn_periph_s periph = '0;
  ifn_pkg::ifn_cpu_s cpu = '0;
  ifn_pkg::ifn_src_e int_src;
  int err_total = 0, n_tests = 0;

  always #2 pclk = ~pclk;

  ifn_irq_flags #(.NPINS(6)) ifn_irq_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph(periph), .cpu(cpu), .nmi_pin(nmi_pin),
    .irq_pin(irq_pin), .nmi_ack(nmi_ack), .int_req(int_req), .int_level(int_level),
    .int_src(int_src), .nmi_req(nmi_req), .wake(wake));
  ifn_cpu_partner ifn_cpu_partner_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .nmi_req(nmi_req), .nmi_ack(nmi_ack));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task chk_src(input ifn_pkg::ifn_src_e e);
    n_tests++;
    if (int_src !== e) begin
      err_total++;
      $display("[FAIL] int_src expected %0d seen %0d", e, int_src);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task t_flags;
    apb(0, 8'h00, 0);
    chk("flags_a reset", 32'h0, rd);
    for (int i = 0; i < 12; i++) begin
      p = (i == 11) ? 11'h7FF : 11'(1 << i);
      @(posedge pclk);
      periph <= p;
      apb(0, 8'h00, 0);
      chk("flags_a", {24'h0, p[10], 1'b0, p[9], p[8], p[7:4]}, rd);
      apb(0, 8'h04, 0);
      chk("flags_b", {27'h0, p[3], p[2], 1'b0, p[1], p[0]}, rd);
    end
    @(posedge pclk);
    periph <= '0;
    apb(1, 8'h00, 32'hFF);
    apb(0, 8'h00, 0);
    chk("flags_a withdrawn", 32'h0, rd);
    apb(0, 8'h20, 0);
    chk("pslverr", 32'h1, {31'h0, er});
    $display("test flags done");
  endtask

  task nmi_pulse;
    @(posedge pclk);
    nmi_pin <= 1'b1;
    repeat (2) @(posedge pclk); // Held two clocks
    nmi_pin <= 1'b0;
  endtask

  task nmi_exp(input logic e, input logic ew);
    logic s, w;
    logic [4:0] l;
    s = 0;
    w = 0;
    l = 0;
    repeat (14) begin
      settle(1);
      if (nmi_req === 1'b1) begin
        s = 1;
        l = int_level;
      end
      if (wake === 1'b1) w = 1;
    end
    chk("nmi_req", {31'h0, e}, {31'h0, s});
    if (e) chk("nmi level", 32'h10, {27'h0, l});
    chk("wake", {31'h0, ew}, {31'h0, w});
  endtask

  task t_nmi;
    apb(1, 8'h08, 32'h1);
    nmi_pulse;
    nmi_exp(1, 0);
    apb(1, 8'h08, 32'h0);
    slow <= 1'b1;
    nmi_pulse;
    nmi_exp(1, 0);
    apb(1, 8'h0C, 32'h8000);
    nmi_pulse;
    nmi_exp(0, 0);
    apb(1, 8'h0C, 32'h0);
    nmi_exp(1, 0);
    @(posedge pclk);
    cpu.cpu_block_bit <= 1'b1;
    nmi_pulse;
    nmi_exp(0, 0);
    apb(1, 8'h0C, 32'h4000);
    nmi_exp(1, 0);
    apb(1, 8'h0C, 32'h0);
    nmi_pulse;
    nmi_exp(0, 0);
    @(posedge pclk);
    cpu.sleep <= 1'b1;
    nmi_exp(1, 1);
    @(posedge pclk);
    cpu <= '0;
    $display("test nmi done");
  endtask

  task t_pins;
    apb(1, 8'h10, 32'h5);
    irq_pin <= 6'h01; // Held through the level checks, then moved to pin 1
    settle(3);
    chk("int_req", 32'h1, {31'h0, int_req});
    chk("int_level", 32'h5, {27'h0, int_level});
    chk_src(ifn_pkg::IFN_SRC_PIN);
    @(posedge pclk);
    irq_pin <= 6'h02;
    settle(3);
    chk("int_req lvl0", 32'h0, {31'h0, int_req});
    apb(0, 8'h18, 0);
    chk("pin flags", 32'h2, rd);
    irq_pin <= 6'h00;
    cpu.cpu_mask_level <= 4'hF;
    apb(1, 8'h0C, 32'h1);
    apb(1, 8'h18, 32'h0);
    cpu.cpu_mask_level <= 4'h0;
    @(posedge pclk);
    irq_pin <= 6'h01;
    repeat (3) @(posedge pclk); // Longer than two clocks
    irq_pin <= 6'h00;
    settle(3);
    chk("edge int_level", 32'h5, {27'h0, int_level});
    @(posedge pclk);
    cpu.cpu_mask_level <= 4'h5;
    settle(3);
    chk("masked int_req", 32'h0, {31'h0, int_req});
    apb(0, 8'h18, 0);
    chk("edge flag", 32'h1, rd);
    apb(1, 8'h18, 32'h0);
    apb(0, 8'h18, 0);
    chk("edge cleared", 32'h0, rd);
    $display("test pins done");
  endtask

  task t_standby;
    apb(1, 8'h0C, 32'h0);
    cpu.standby <= 1'b1;
    cpu.rtc_in_use <= 1'b1;
    cpu.cpu_mask_level <= 4'h4;
    irq_pin <= 6'h01;
    settle(3);
    chk("wake before tick", 32'h0, {31'h0, wake});
    @(posedge pclk);
    cpu.rtc_tick <= 1'b1;
    @(posedge pclk);
    cpu.rtc_tick <= 1'b0;
    settle(3);
    chk("wake on tick", 32'h1, {31'h0, wake});
    chk("standby int_level", 32'h5, {27'h0, int_level});
    @(posedge pclk);
    cpu.rtc_in_use <= 1'b0;
    settle(2);
    chk("wake without rtc", 32'h0, {31'h0, wake});
    @(posedge pclk);
    cpu.cpu_block_bit <= 1'b1;
    nmi_pulse;
    nmi_exp(1, 1);
    @(posedge pclk);
    cpu <= '0;
    irq_pin <= 6'h00;
    $display("test standby done");
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #80000;
    err_total++;
    stop_test;
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_flags;
    t_nmi;
    t_pins;
    t_standby;
    stop_test;
  end
endmodule // tb_irq_flags_and_nmi_detect
